// [rtl/adm_pkg.sv]
// Purpose: shared constants for the conversion result monitor
// Assumes: 32-bit classic Wishbone register access, byte addresses
// Notes: control layout is shared by both monitor units
package adm_pkg;
   // register byte offsets
   localparam logic [7:0] MON0_CONTROL_OFS = 8'h00;
   localparam logic [7:0] MON1_CONTROL_OFS = 8'h04;
   localparam logic [7:0] MON0_THRESHOLD_OFS = 8'h08;
   localparam logic [7:0] MON1_THRESHOLD_OFS = 8'h0C;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
   localparam logic [7:0] IRQ_CLEAR_OFS = 8'h14;
   localparam logic [7:0] IRQ_ENABLE_OFS = 8'h18;
   // stride between per-monitor registers
   localparam int MON_STRIDE = 4;
   // control field positions
   localparam int SRC_SEL_LSB = 0;
   localparam int SRC_SEL_W = 4;
   localparam int DIRECTION_BIT = 4;
   localparam int METHOD_BIT = 5;
   localparam int ENABLE_BIT = 7;
   localparam int TARGET_LSB = 8;
   localparam int TARGET_W = 4;
   localparam int CONTROL_W = 12;
   // writable control bits (bit 6 reads as zero)
   localparam logic [11:0] CONTROL_WMASK = 12'hFBF;
   localparam logic [11:0] CONTROL_RESET = 12'h000;
   // threshold field
   localparam int THRESHOLD_W = 12;
   localparam logic [11:0] THRESHOLD_RESET = 12'h000;
   // counter width holds target plus one
   localparam int COUNT_W = 5;
   // direction and method encodings
   localparam logic DIR_GREATER = 1'b0;
   localparam logic DIR_SMALLER = 1'b1;
   localparam logic METHOD_CONSECUTIVE = 1'b0;
   localparam logic METHOD_CUMULATIVE = 1'b1;
endpackage

// [rtl/adm_monitor.sv]
// Purpose: two conversion result monitors with threshold compare and match counting
// Assumes: conversion done is a one-cycle pulse with result and register index valid
// Notes: per-monitor event pulses plus one gated level interrupt
//
// What this block does
// - consecutive mode fires once successive matches reach the count target
// - consecutive mode fires on every further match after the target is passed
// - consecutive mode clears the counter on any failing conversion
// - cumulative mode fires and clears the counter when the total reaches target
// - cumulative mode keeps the counter unchanged on a failing conversion
// - direction 0 matches a result greater than the threshold
// - direction 1 matches a result smaller than the threshold
// - compare on every completed conversion of the selected source register
// - a matching result increments the match counter
// - monitor 0 threshold is 12 write-only bits, upper bits read zero
// - count target field value plus one is the required match count
// - method bit 0 selects consecutive, 1 selects cumulative counting
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module adm_monitor #(
   parameter int NUM_MON = 2,
   parameter int ADR_W = 8
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [ADR_W-1:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // conversion results from the sequencer
   input wire logic CONV_DONE,
   input wire logic [3:0] CONV_REG_IDX,
   input wire logic [11:0] CONV_RESULT,
   // interrupts
   output logic [NUM_MON-1:0] MONITOR_IRQ,
   output logic IRQ
);

   // refuse sizes the decode and the read select cannot serve
   generate
      if (NUM_MON < 1 || NUM_MON > 2) begin : g_bad_num
         $error("NUM_MON must be 1 or 2");
      end
      if (ADR_W < 5) begin : g_bad_adr
         $error("ADR_W must be at least 5");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [NUM_MON-1:0] status_reg;
   logic [NUM_MON-1:0] enable_reg;
   logic [NUM_MON-1:0] event_reg;
   wire [NUM_MON*adm_pkg::CONTROL_W-1:0] ctrl_flat;
   wire [NUM_MON-1:0] event_now;

   wire bus_req = WB_CYC_I & WB_STB_I & ~ack_reg;
   wire bus_wr = bus_req & WB_WE_I;
   // offsets fit in five bits, so any address width from five up decodes them
   wire [ADR_W-1:0] word_ofs = {WB_ADR_I[ADR_W-1:2], 2'b00};
   wire [31:0] byte_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
   wire hit_ctrl0 = word_ofs == ADR_W'(adm_pkg::MON0_CONTROL_OFS);
   wire hit_ctrl1 = word_ofs == ADR_W'(adm_pkg::MON1_CONTROL_OFS);
   wire hit_thr0 = word_ofs == ADR_W'(adm_pkg::MON0_THRESHOLD_OFS);
   wire hit_thr1 = word_ofs == ADR_W'(adm_pkg::MON1_THRESHOLD_OFS);
   wire hit_status = word_ofs == ADR_W'(adm_pkg::IRQ_STATUS_OFS);
   wire hit_clear = word_ofs == ADR_W'(adm_pkg::IRQ_CLEAR_OFS);
   wire hit_enable = word_ofs == ADR_W'(adm_pkg::IRQ_ENABLE_OFS);
   wire [NUM_MON-1:0] hit_ctrl = NUM_MON'({hit_ctrl1, hit_ctrl0});
   wire [NUM_MON-1:0] hit_thr = NUM_MON'({hit_thr1, hit_thr0});
   wire [31:0] wdata_masked = WB_DAT_I & byte_mask;
   wire [NUM_MON-1:0] clear_bits = (bus_wr && hit_clear) ? wdata_masked[NUM_MON-1:0] : '0;

   ////////////////////////////////////////////////////////////////////////////
   // read data select

   logic [NUM_MON*adm_pkg::CONTROL_W-1:0] ctrl_pad;
   assign ctrl_pad = ctrl_flat;

   wire [11:0] ctrl0_rd = ctrl_pad[11:0];
   wire [11:0] ctrl1_rd = (NUM_MON > 1) ? ctrl_pad[NUM_MON*12-1 -: 12] : 12'h000;
   wire [31:0] rd_mux =
      (hit_ctrl0) ? {20'h00000, ctrl0_rd} :
      (hit_ctrl1 && NUM_MON > 1) ? {20'h00000, ctrl1_rd} :
      (hit_status) ? 32'(status_reg) :
      (hit_enable) ? 32'(enable_reg) :
      32'h00000000;
   // thresholds and the clear register are write-only and read as zero

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else begin
         ack_reg <= bus_req;
         rdata_reg <= bus_req ? rd_mux : 32'h00000000;
      end
   end

   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // monitor units

   genvar i;
   generate
      for (i = 0; i < NUM_MON; i++) begin : g_mon
         logic [11:0] ctrl_reg;
         logic [11:0] ctrl_next;
         logic [11:0] thr_reg;
         logic [11:0] thr_next;
         logic [adm_pkg::COUNT_W-1:0] cnt_reg;
         logic [adm_pkg::COUNT_W-1:0] cnt_next;
         logic fire;

         wire enabled = ctrl_reg[adm_pkg::ENABLE_BIT];
         wire direction = ctrl_reg[adm_pkg::DIRECTION_BIT];
         wire method = ctrl_reg[adm_pkg::METHOD_BIT];
         wire [3:0] src_sel = ctrl_reg[adm_pkg::SRC_SEL_LSB +: adm_pkg::SRC_SEL_W];
         wire [3:0] target = ctrl_reg[adm_pkg::TARGET_LSB +: adm_pkg::TARGET_W];
         wire [adm_pkg::COUNT_W-1:0] need = {1'b0, target} + 5'h01;
         wire sample = CONV_DONE && (CONV_REG_IDX == src_sel);
         wire above = CONV_RESULT > thr_reg;
         wire below = CONV_RESULT < thr_reg;
         wire match = (direction == adm_pkg::DIR_SMALLER) ? below : above;
         wire [adm_pkg::COUNT_W-1:0] cnt_inc = (cnt_reg == 5'h1F) ? cnt_reg : cnt_reg + 5'h01;

         // register writes with byte lanes; thresholds written regardless of enable
         // selected lanes take the new bits, zeros included, so a write can disable
         assign ctrl_next = (bus_wr && hit_ctrl[i]) ?
            (((ctrl_reg & ~byte_mask[11:0]) | wdata_masked[11:0]) & adm_pkg::CONTROL_WMASK) :
            ctrl_reg;
         assign thr_next = (bus_wr && hit_thr[i]) ?
            ((thr_reg & ~byte_mask[11:0]) | wdata_masked[11:0]) : thr_reg;

         // counting and event generation
         always_comb begin
            cnt_next = cnt_reg;
            fire = 1'b0;
            if (!enabled) begin
               cnt_next = '0;
            end else if (sample) begin
               if (method == adm_pkg::METHOD_CONSECUTIVE) begin
                  if (match) begin
                     cnt_next = cnt_inc;
                     fire = cnt_inc >= need;
                  end else begin
                     cnt_next = '0;
                  end
               end else begin
                  if (match) begin
                     if (cnt_inc >= need) begin
                        cnt_next = '0;
                        fire = 1'b1;
                     end else begin
                        cnt_next = cnt_inc;
                     end
                  end else begin
                     cnt_next = cnt_reg;
                  end
               end
            end
         end

         always_ff @(posedge CORE_CLK or posedge RST) begin
            if (RST) begin
               ctrl_reg <= adm_pkg::CONTROL_RESET;
               thr_reg <= adm_pkg::THRESHOLD_RESET;
               cnt_reg <= '0;
            end else begin
               ctrl_reg <= ctrl_next;
               thr_reg <= thr_next;
               cnt_reg <= cnt_next;
            end
         end

         assign ctrl_flat[i*12 +: 12] = ctrl_reg;
         assign event_now[i] = fire;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, clear and enable

   wire [NUM_MON-1:0] status_next = event_now | (status_reg & ~clear_bits);
   wire [NUM_MON-1:0] enable_next = (bus_wr && hit_enable) ?
      ((enable_reg & ~byte_mask[NUM_MON-1:0]) | wdata_masked[NUM_MON-1:0]) : enable_reg;

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         status_reg <= '0;
         enable_reg <= '0;
         event_reg <= '0;
      end else begin
         status_reg <= status_next;
         enable_reg <= enable_next;
         event_reg <= event_now;
      end
   end

   assign MONITOR_IRQ = event_reg;
   assign IRQ = |(status_reg & enable_reg);

endmodule

// [tb/adm_seq_model.sv]
// Purpose: conversion sequencer model
// Assumes: repeat mode, one result per call
// Notes: idle lines show the inverted last value
`timescale 1ns/1ps
module adm_seq_model (
   // clock and results
   input wire logic CORE_CLK,
   output logic CONV_DONE,
   output logic [3:0] CONV_REG_IDX,
   output logic [11:0] CONV_RESULT
);
   initial begin
      CONV_DONE = 1'b0;
      CONV_REG_IDX = 4'h0;
      CONV_RESULT = 12'h000;
   end
   // one completed conversion in repeat mode
   task automatic conv(input logic [3:0] i, input logic [11:0] v);
      @(posedge CORE_CLK);
      CONV_DONE <= 1'b1;
      CONV_REG_IDX <= i;
      CONV_RESULT <= v;
      @(posedge CORE_CLK);
      CONV_DONE <= 1'b0;
      CONV_REG_IDX <= ~i;
      CONV_RESULT <= ~v;
   endtask
endmodule

// [tb/adm_monitor_sva.sv]
// Purpose: port checks of the result monitor
// Assumes: source select left at 0000
// Notes: bound from the bench top
`timescale 1ns/1ps
module adm_monitor_sva #(
   parameter int NUM_MON = 2,
   parameter int ADR_W = 8
) (
   // clock, reset, bus
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [ADR_W-1:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   // conversions and interrupts
   input wire logic CONV_DONE,
   input wire logic [3:0] CONV_REG_IDX,
   input wire logic [NUM_MON-1:0] MONITOR_IRQ,
   input wire logic IRQ
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   wire logic req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   wire logic thr = WB_ADR_I[7:2] == adm_pkg::MON0_THRESHOLD_OFS[7:2];
   ////////////////////////////////////////
   a_ack_next: assert property (req |=> WB_ACK_O) else $error("no ack after request");
   a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
   a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("read data without ack");
   a_thr_zero: assert property (req && !WB_WE_I && thr |=> WB_DAT_O == 32'h0)
      else $error("threshold read not zero");
   a_irq_cause: assert property (|MONITOR_IRQ |-> $past(CONV_DONE))
      else $error("event without conversion");
   a_idx_ignore: assert property (CONV_DONE && CONV_REG_IDX != 4'h0 |=> MONITOR_IRQ == '0)
      else $error("event from other register");
   a_rise_cause: assert property ($rose(IRQ) |-> (|MONITOR_IRQ) || WB_ACK_O)
      else $error("irq rose without cause");
   a_fall_cause: assert property ($fell(IRQ) |-> WB_ACK_O && $past(WB_WE_I))
      else $error("irq fell without write");
   c_mon0: cover property (MONITOR_IRQ[0]);
   c_mon1: cover property (MONITOR_IRQ[NUM_MON-1]);
   c_clear: cover property ($fell(IRQ));
endmodule

// [tb/adm_monitor_tb.sv]
// Purpose: self-checking bench for the result monitor
// Assumes: every access waits for ack; the watchdog bounds the wait
// Notes: the sequencer model drives conversions
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module adm_monitor_tb;
   logic clk, rst, cyc, stb, we, ack, done, irq;
   logic [7:0] adr;
   logic [31:0] dat, dat_o, q;
   logic [3:0] idx;
   logic [11:0] res;
   logic [1:0] mirq;
   int errors = 0;
   int n_checks = 0;
   logic [11:0] s1 [9] = '{12'h801, 12'h900, 12'h800, 12'h801, 12'hFFF, 12'h900, 12'h900, 12'h100, 12'h900};
   logic [8:0] e1 = 9'b000001100;
   logic [11:0] s2 [6] = '{12'h3FF, 12'h500, 12'h000, 12'h100, 12'h400, 12'h3FF};
   logic [5:0] e2 = 6'b001001;
   adm_monitor i_adm_monitor (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .CONV_DONE(done),
      .CONV_REG_IDX(idx), .CONV_RESULT(res), .MONITOR_IRQ(mirq), .IRQ(irq));
   adm_seq_model i_adm_seq_model (.CORE_CLK(clk), .CONV_DONE(done), .CONV_REG_IDX(idx), .CONV_RESULT(res));
   ////////////////////////////////////////
   task automatic wr(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wr(1'b0, a, 32'h0);
      `CHK($sformatf("reg %0h", a), e, q)
   endtask
   task automatic cv(input logic [3:0] i, input logic [11:0] v, input logic [1:0] e);
      i_adm_seq_model.conv(i, v);
      #1 `CHK($sformatf("event %0h", v), e, mirq)
   endtask
   task summarize;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #2000000;
      errors++;
      summarize;
   end
   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      dat = 32'h0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(8'h00, 32'h0);
      wr(1'b1, 8'h00, 32'hFFFFFF70);
      rd(8'h00, 32'h00000F30);
      wr(1'b1, 8'h08, 32'hFFFFF800);
      rd(8'h08, 32'h0);
      wr(1'b1, 8'h1C, 32'hFFFFFFFF);
      rd(8'h1C, 32'h0);
      wr(1'b1, 8'h18, 32'h1);
      wr(1'b1, 8'h00, 32'h00000280);
      for (int i = 0; i < 9; i++) cv(4'h0, s1[i], {1'b0, e1[8-i]});
      `CHK("irq", 1'b1, irq)
      rd(8'h10, 32'h1);
      wr(1'b1, 8'h14, 32'h1);
      `CHK("irq", 1'b0, irq)
      wr(1'b1, 8'h00, 32'h0);
      wr(1'b1, 8'h08, 32'h400);
      wr(1'b1, 8'h00, 32'h000001B0);
      for (int i = 0; i < 6; i++) cv(4'h0, s2[i], {1'b0, e2[5-i]});
      repeat (2) cv(4'h3, 12'h000, 2'b00);
      wr(1'b1, 8'h14, 32'h3);
      wr(1'b1, 8'h00, 32'h00000010);
      wr(1'b1, 8'h0C, 32'h010);
      wr(1'b1, 8'h04, 32'h00000080);
      cv(4'h0, 12'h005, 2'b00);
      cv(4'h0, 12'h020, 2'b10);
      rd(8'h10, 32'h2);
      `CHK("irq", 1'b0, irq)
      wr(1'b1, 8'h18, 32'h3);
      `CHK("irq", 1'b1, irq)
      summarize;
   end
endmodule
bind adm_monitor adm_monitor_sva #(.NUM_MON(NUM_MON), .ADR_W(ADR_W)) i_adm_monitor_sva (.*);
